//--- include/spm_pkg.sv
`default_nettype none
package spm_pkg;
	// bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PIN_W  = 16;	// port B in [7:0], port C in [15:8]
	localparam int unsigned CH_N   = 4;

	// register byte offsets
	localparam logic [7:0] OFS_PORTB_DATA = 8'h00;
	localparam logic [7:0] OFS_PORTC_DATA = 8'h04;
	localparam logic [7:0] OFS_PORTB_DIR  = 8'h08;
	localparam logic [7:0] OFS_PORTC_DIR  = 8'h0C;
	localparam logic [7:0] OFS_FUNC       = 8'h10;
	localparam logic [7:0] OFS_PIN_LEVEL  = 8'h14;
	localparam logic [7:0] OFS_STATUS     = 8'h18;

	// reset values
	localparam logic [7:0]  RST_PORT_DATA = 8'h00;
	localparam logic [7:0]  RST_PORT_DIR  = 8'h00;
	localparam logic [14:0] RST_FUNC      = 15'h0000;

	// pin positions within the combined pin vector, per serial channel
	localparam int TX_POS  [CH_N] = '{0, 3, 6, 9};
	localparam int RX_POS  [CH_N] = '{1, 4, 7, 10};
	localparam int CLK_POS [CH_N] = '{2, 5, 8, 11};
	localparam int CTS_POS = 12;
	localparam int TRG_POS = 13;
	localparam int OUT_ONLY_POS = 2;	// clock pin of channel 0
	localparam int STAT_STABLE_POS = 0;

	// oscillation stabilisation wait, in aclk cycles
	localparam logic [12:0] STAB_WAIT_CYCLES = 13'h1000;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// pin function enables, software written
	typedef struct packed {
		logic       ext_req_en;
		logic       trg_en;
		logic       cts_en;
		logic [3:0] ext_clk_mode;
		logic [3:0] clk_out_en;
		logic [3:0] tx_en;
	} spm_func_t;

	// level and enable that go to one pin pad
	typedef struct packed {
		logic out;
		logic oe;
	} spm_drive_t;

	typedef enum logic [1:0] {
		WS_COLLECT = 2'b01,
		WS_RESP    = 2'b10
	} spm_wstate_t;

	typedef enum logic [1:0] {
		RS_ADDR = 2'b01,
		RS_DATA = 2'b10
	} spm_rstate_t;
endpackage : spm_pkg
`default_nettype wire

//--- design/spm_chan_cell.sv
`default_nettype none
module spm_chan_cell
	import spm_pkg::*;
(
	input  wire logic       tx_en,
	input  wire logic       clk_out_en,
	input  wire logic       ext_clk_mode,
	input  wire spm_drive_t tx_port,
	input  wire spm_drive_t clk_port,
	input  wire logic       serial_tx,
	input  wire logic       serial_sck,
	input  wire logic       clk_pin_level,
	output spm_drive_t      tx_drive,
	output spm_drive_t      clk_drive,
	output logic            ext_clk
);
	// transmit pin: while tx_en is set the transmitter owns the pad, port latches ignored
	always_comb
	begin
		if (tx_en)
		begin
			tx_drive.out = serial_tx;	// [R1] [R5] [R13]
			tx_drive.oe  = 1'b1;
		end
		else
		begin
			tx_drive = tx_port;	// [R1]
		end
	end

	// clock pin: shift clock out only while its enable is set
	always_comb
	begin
		if (clk_out_en)
		begin
			clk_drive.out = serial_sck;	// [R2] [R5] [R13]
			clk_drive.oe  = 1'b1;
		end
		else
		begin
			clk_drive = clk_port;	// [R2]
		end
	end

	// external clock taken only with the port set to input and the mode chosen
	assign ext_clk = (!clk_port.oe && ext_clk_mode) ? clk_pin_level : 1'b0;	// [R3]
endmodule : spm_chan_cell
`default_nettype wire

//--- design/spm_pin_share.sv
// Operation
// R1: tx enable hands ch0-2 data pin to transmitter
// R2: clock pin driven by shift clock when enabled
// R3: external clock from pin in input mode
// R4: receive pins always sampled, port stays usable
// R5: channel 3 shares its pins the same way
// R6: clear-to-send sampled from pin when enabled
// R7: pulse trigger routed from pin when enabled
// R8: request pin accepted whenever requests enabled
// R9: request pin also starts the converter
// R10: ch0 clock pin is output-only port bit; code only reads back its latch, and its direction still follows port_dir_reg
// R11: reset held low at least five cycles
// R12: stabilisation wait after reset and stop wake
// R13: peripheral-owned pins ignore port data and direction
`default_nettype none
module spm_pin_share
	import spm_pkg::*;
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [DATA_W-1:0]   s_axi_wdata,
	input  wire logic [DATA_W/8-1:0] s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [PIN_W-1:0]    pin_in,
	output logic [PIN_W-1:0]         pin_out,
	output logic [PIN_W-1:0]         pin_oe,
	input  wire logic                req2_pin_in,
	input  wire logic [CH_N-1:0]     serial_tx,
	input  wire logic [CH_N-1:0]     serial_sck,
	input  wire logic                stop_wake,
	output logic [CH_N-1:0]          serial_rx,
	output logic [CH_N-1:0]          serial_ext_clk,
	output logic                     clear_to_send_in_ch0,
	output logic                     pulse_gen_trigger_in,
	output logic                     ext_request_in_2,
	output logic                     converter_start_trigger_in,
	output logic                     osc_stable
);
	import spm_pkg::*;

	// bus side registers
	spm_wstate_t       wstate_reg;
	spm_rstate_t       rstate_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic [3:0]        wstrb_reg;

	// software visible state
	logic [PIN_W-1:0]  port_data_reg;
	logic [PIN_W-1:0]  port_dir_reg;
	spm_func_t         func_reg;
	logic [PIN_W-1:0]  pin_level_reg;
	logic [12:0]       stab_cnt_reg;
	logic              osc_stable_reg;

	// pad and peripheral facing registers
	logic [PIN_W-1:0]  pin_out_reg;
	logic [PIN_W-1:0]  pin_oe_reg;
	logic [CH_N-1:0]   serial_rx_reg;
	logic [CH_N-1:0]   ext_clk_reg;
	logic              cts_reg;
	logic              trg_reg;
	logic              req2_reg;
	logic              adc_trg_reg;

	// combinational helpers
	logic              aw_have;
	logic              w_have;
	logic              wr_fire;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [3:0]        wr_strb;
	logic              wr_mapped;
	logic [DATA_W-1:0] rd_word;
	logic              rd_mapped;
	logic [PIN_W-1:0]  pin_level_view;
	logic [15:0]       func_merged;
	spm_drive_t        drive_next [PIN_W];
	spm_drive_t        tx_drive   [CH_N];
	spm_drive_t        clk_drive  [CH_N];
	logic [CH_N-1:0]   ext_clk_next;

	// byte-lane merge, used for the function register only; port registers take lane 0 inline
	function automatic logic [15:0] merge16(
		input logic [15:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  strb
	);
		logic [15:0] res;
		res = old_val;
		if (strb[0])
			res[7:0] = new_val[7:0];
		if (strb[1])
			res[15:8] = new_val[15:8];
		return res;
	endfunction : merge16

	// an address or data beat counts as held once ready has dropped
	assign aw_have = !awready_reg || s_axi_awvalid;
	assign w_have  = !wready_reg || s_axi_wvalid;
	assign wr_fire = (wstate_reg == WS_COLLECT) && aw_have && w_have;
	assign wr_addr = awready_reg ? s_axi_awaddr : awaddr_reg;
	assign wr_data = wready_reg ? s_axi_wdata : wdata_reg;
	assign wr_strb = wready_reg ? s_axi_wstrb : wstrb_reg;

	// function word after the lane merge; bit 15 has no storage behind it
	assign func_merged = merge16({1'b0, func_reg}, wr_data, wr_strb);

	// write address decode; the pin level and status words are read only
	always_comb
	begin
		unique case ({wr_addr[7:2], 2'h0})
			OFS_PORTB_DATA, OFS_PORTC_DATA, OFS_PORTB_DIR,
			OFS_PORTC_DIR, OFS_FUNC: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	// hold address and data that arrive before their partner
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_reg <= 8'h00;
			wdata_reg  <= 32'h00000000;
			wstrb_reg  <= 4'h0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && awready_reg)
				awaddr_reg <= s_axi_awaddr;
			if (s_axi_wvalid && wready_reg)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
		end
	end

	// write channel sequencing: collect both beats, then respond
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wstate_reg  <= WS_COLLECT;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end
		else if (ce)
		begin
			unique case (wstate_reg)
				WS_COLLECT:
				begin
					if (s_axi_awvalid && awready_reg)
						awready_reg <= 1'b0;
					if (s_axi_wvalid && wready_reg)
						wready_reg <= 1'b0;
					if (wr_fire)
					begin
						awready_reg <= 1'b0;
						wready_reg  <= 1'b0;
						bvalid_reg  <= 1'b1;
						bresp_reg   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
						wstate_reg  <= WS_RESP;
					end
				end
				WS_RESP:
				begin
					if (s_axi_bready)
					begin
						bvalid_reg  <= 1'b0;
						awready_reg <= 1'b1;
						wready_reg  <= 1'b1;
						wstate_reg  <= WS_COLLECT;
					end
				end
			endcase
		end
	end

	// software writes to port latches, directions and pin functions
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			port_data_reg <= {RST_PORT_DATA, RST_PORT_DATA};
			port_dir_reg  <= {RST_PORT_DIR, RST_PORT_DIR};
			func_reg      <= RST_FUNC;
		end
		else if (ce && wr_fire)
		begin
			unique case ({wr_addr[7:2], 2'h0})
				OFS_PORTB_DATA:
					port_data_reg[7:0] <= wr_strb[0] ? wr_data[7:0] : port_data_reg[7:0];
				OFS_PORTC_DATA:
					port_data_reg[15:8] <= wr_strb[0] ? wr_data[7:0] : port_data_reg[15:8];
				OFS_PORTB_DIR:
					port_dir_reg[7:0] <= wr_strb[0] ? wr_data[7:0] : port_dir_reg[7:0];
				OFS_PORTC_DIR:
					port_dir_reg[15:8] <= wr_strb[0] ? wr_data[7:0] : port_dir_reg[15:8];
				OFS_FUNC:
					func_reg <= spm_func_t'(func_merged[14:0]);
				default:
					port_data_reg <= port_data_reg;
			endcase
		end
	end

	// the ch0 clock pin reads back its latch while it is a port bit
	always_comb
	begin
		pin_level_view = pin_level_reg;
		if (!func_reg.clk_out_en[0])
			pin_level_view[OUT_ONLY_POS] = port_data_reg[OUT_ONLY_POS];	// [R10]
	end

	// read data mux; unmapped words answer zero with an error
	always_comb
	begin
		rd_word   = 32'h00000000;
		rd_mapped = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'h0})
			OFS_PORTB_DATA: rd_word[7:0]  = port_data_reg[7:0];
			OFS_PORTC_DATA: rd_word[7:0]  = port_data_reg[15:8];
			OFS_PORTB_DIR:  rd_word[7:0]  = port_dir_reg[7:0];
			OFS_PORTC_DIR:  rd_word[7:0]  = port_dir_reg[15:8];
			OFS_FUNC:       rd_word[14:0] = func_reg;
			OFS_PIN_LEVEL:  rd_word[15:0] = pin_level_view;	// [R4]
			OFS_STATUS:     rd_word[STAT_STABLE_POS] = osc_stable_reg;
			default:        rd_mapped = 1'b0;
		endcase
	end

	// read channel: one word per address beat
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rstate_reg  <= RS_ADDR;
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= 32'h00000000;
		end
		else if (ce)
		begin
			unique case (rstate_reg)
				RS_ADDR:
				begin
					if (s_axi_arvalid)
					begin
						rdata_reg   <= rd_word;
						rresp_reg   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
						rvalid_reg  <= 1'b1;
						arready_reg <= 1'b0;
						rstate_reg  <= RS_DATA;
					end
				end
				RS_DATA:
				begin
					if (s_axi_rready)
					begin
						rvalid_reg  <= 1'b0;
						arready_reg <= 1'b1;
						rstate_reg  <= RS_ADDR;
					end
				end
			endcase
		end
	end

	// per-channel sharing of transmit and clock pins
	genvar ch;
	generate
		for (ch = 0; ch < CH_N; ch++)
		begin : g_chan
			spm_chan_cell u_cell (
				.tx_en         (func_reg.tx_en[ch]),
				.clk_out_en    (func_reg.clk_out_en[ch]),
				.ext_clk_mode  (func_reg.ext_clk_mode[ch]),
				.tx_port       ({port_data_reg[TX_POS[ch]], port_dir_reg[TX_POS[ch]]}),
				.clk_port      ({port_data_reg[CLK_POS[ch]], port_dir_reg[CLK_POS[ch]]}),
				.serial_tx     (serial_tx[ch]),
				.serial_sck    (serial_sck[ch]),
				.clk_pin_level (pin_in[CLK_POS[ch]]),
				.tx_drive      (tx_drive[ch]),
				.clk_drive     (clk_drive[ch]),
				.ext_clk       (ext_clk_next[ch])	// [R3]
			);
		end
	endgenerate

	// pad drive: plain port bits by default, peripheral outputs override
	always_comb
	begin
		for (int i = 0; i < PIN_W; i++)
		begin
			drive_next[i].out = port_data_reg[i];
			drive_next[i].oe  = port_dir_reg[i];
		end
		for (int c = 0; c < CH_N; c++)
		begin
			drive_next[TX_POS[c]]  = tx_drive[c];	// [R1] [R5] [R13]
			drive_next[CLK_POS[c]] = clk_drive[c];	// [R2] [R5] [R13]
		end
	end

	// register the pads so no combinational path reaches a pin
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_out_reg <= 16'h0000;
			pin_oe_reg  <= 16'h0000;
		end
		else if (ce)
		begin
			for (int i = 0; i < PIN_W; i++)
			begin
				pin_out_reg[i] <= drive_next[i].out;
				pin_oe_reg[i]  <= drive_next[i].oe;
			end
		end
	end

	// sample pin levels for software and for the receivers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_level_reg <= 16'h0000;
			serial_rx_reg <= 4'hF;
			ext_clk_reg   <= 4'h0;
		end
		else if (ce)
		begin
			pin_level_reg <= pin_in;	// [R4]
			for (int c = 0; c < CH_N; c++)
				serial_rx_reg[c] <= pin_in[RX_POS[c]];	// [R4] [R5]
			ext_clk_reg <= ext_clk_next;	// [R3]
		end
	end

	// optional input functions plus the always-on converter trigger; disabled inputs rest low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cts_reg     <= 1'b0;
			trg_reg     <= 1'b0;
			req2_reg    <= 1'b0;
			adc_trg_reg <= 1'b0;
		end
		else if (ce)
		begin
			cts_reg     <= func_reg.cts_en ? pin_in[CTS_POS] : 1'b0;	// [R6]
			trg_reg     <= func_reg.trg_en ? pin_in[TRG_POS] : 1'b0;	// [R7]
			req2_reg    <= func_reg.ext_req_en ? req2_pin_in : 1'b0;	// [R8]
			adc_trg_reg <= req2_pin_in;	// [R9]
		end
	end

	// stabilisation wait restarts at reset and at every stop wake-up;
	// reset is synchronous so the driver must hold it several edges
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stab_cnt_reg   <= STAB_WAIT_CYCLES;	// [R12] [R11]
			osc_stable_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (stop_wake)
			begin
				stab_cnt_reg   <= STAB_WAIT_CYCLES;	// [R12]
				osc_stable_reg <= 1'b0;
			end
			else if (stab_cnt_reg != 13'h0000)
			begin
				stab_cnt_reg   <= stab_cnt_reg - 13'h0001;
				osc_stable_reg <= (stab_cnt_reg == 13'h0001);
			end
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready              = awready_reg;
	assign s_axi_wready               = wready_reg;
	assign s_axi_bvalid               = bvalid_reg;
	assign s_axi_bresp                = bresp_reg;
	assign s_axi_arready              = arready_reg;
	assign s_axi_rvalid               = rvalid_reg;
	assign s_axi_rresp                = rresp_reg;
	assign s_axi_rdata                = rdata_reg;
	assign pin_out                    = pin_out_reg;
	assign pin_oe                     = pin_oe_reg;
	assign serial_rx                  = serial_rx_reg;
	assign serial_ext_clk             = ext_clk_reg;
	assign clear_to_send_in_ch0       = cts_reg;
	assign pulse_gen_trigger_in       = trg_reg;
	assign ext_request_in_2           = req2_reg;
	assign converter_start_trigger_in = adc_trg_reg;
	assign osc_stable                 = osc_stable_reg;
endmodule : spm_pin_share
`default_nettype wire

//--- tb/spm_far_model.sv
`default_nettype none
module spm_far_model
(
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe,
	input  wire logic [15:0] ext_lvl,
	output logic      [15:0] pin_in
);
	// pad level: the block wins where it drives, else the far device's level
	assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : spm_far_model
`default_nettype wire

//--- tb/spm_pin_share_props.sv
`default_nettype none
module spm_pin_share_props
	import spm_pkg::*;
(
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             ce,
	input wire logic [PIN_W-1:0] pin_in,
	input wire logic             req2_pin_in,
	input wire logic             stop_wake,
	input wire logic [CH_N-1:0]  serial_rx,
	input wire logic [CH_N-1:0]  serial_ext_clk,
	input wire logic             clear_to_send_in_ch0,
	input wire logic             pulse_gen_trigger_in,
	input wire logic             ext_request_in_2,
	input wire logic             converter_start_trigger_in,
	input wire logic             osc_stable
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [12:0] wait_cnt;
	// cycles since reset or wake; saturates so it never wraps into the low window
	always_ff @(posedge aclk)
	begin
		if (!aresetn || stop_wake)
			wait_cnt <= 13'h0000;
		else if (ce && wait_cnt != 13'h1FFF)
			wait_cnt <= wait_cnt + 13'h0001;
	end
	AST_RX_FOLLOW: assert property (ce |=> serial_rx == {$past(pin_in[10]),
		$past(pin_in[7]), $past(pin_in[4]), $past(pin_in[1])})
		else $error("rx output does not follow rx pins");
	AST_EXT_CLK_SRC: assert property ((serial_ext_clk & ~{$past(pin_in[11]),
		$past(pin_in[8]), $past(pin_in[5]), $past(pin_in[2])}) == 4'h0)
		else $error("external clock high while its pin was low");
	AST_CTS_SRC: assert property (clear_to_send_in_ch0 |-> $past(pin_in[12]))
		else $error("clear to send high while its pin was low");
	AST_TRG_SRC: assert property (pulse_gen_trigger_in |-> $past(pin_in[13]))
		else $error("pulse trigger high while its pin was low");
	AST_REQ_SRC: assert property (ext_request_in_2 |-> $past(req2_pin_in))
		else $error("request high while its pin was low");
	AST_CONV_FOLLOW: assert property (ce |=> converter_start_trigger_in == $past(req2_pin_in))
		else $error("converter trigger does not follow request pin");
	AST_STAB_LOW: assert property (wait_cnt >= 2 && wait_cnt < 4094 |-> !osc_stable)
		else $error("stable flag before the wait ran out");
	AST_STAB_HIGH: assert property (wait_cnt == 4100 |-> osc_stable)
		else $error("stable flag missing after the wait");
endmodule : spm_pin_share_props
bind spm_pin_share spm_pin_share_props spm_pin_share_props_inst (.aclk, .aresetn, .ce,
	.pin_in, .req2_pin_in, .stop_wake, .serial_rx, .serial_ext_clk, .clear_to_send_in_ch0,
	.pulse_gen_trigger_in, .ext_request_in_2, .converter_start_trigger_in, .osc_stable);
`default_nettype wire

//--- tb/tb_serial_port_pin_sharing.sv
`default_nettype none
module tb_serial_port_pin_sharing
	import spm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, arready;
	logic        bvalid, rvalid, req2, stop_wake, cts, trg, req, conv, osc_stable;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [15:0] pin_in, pin_out, pin_oe, ext_lvl;
	logic [3:0]  serial_tx, serial_sck, serial_rx, ext_clk;
	int          bad_count, cmp_count;
	spm_pin_share spm_pin_share_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .req2_pin_in(req2), .serial_tx(serial_tx),
		.serial_sck(serial_sck), .stop_wake(stop_wake), .serial_rx(serial_rx),
		.serial_ext_clk(ext_clk), .clear_to_send_in_ch0(cts),
		.pulse_gen_trigger_in(trg), .ext_request_in_2(req),
		.converter_start_trigger_in(conv), .osc_stable(osc_stable));
	spm_far_model spm_far_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_lvl(ext_lvl), .pin_in(pin_in));
	// free-running bench clock, 4 ns period
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask : wait_n
	// bready stays high, so the response is taken at the edge where bvalid is seen
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		chk("bvalid", 32'(bvalid), 32'h1);
		chk("bresp", 32'(bresp), 32'(er));
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		chk("rvalid", 32'(rvalid), 32'h1);
		chk("rresp", 32'(rresp), 32'(er));
		chk("rdata", rdata & m, ed);
	endtask : axi_rd
	// reset values, byte lane use, refused accesses
	task automatic t_regs;
		for (int i = 0; i < 7; i++)
			axi_rd(8'(4 * i), 32'hFFFFFFFF, 32'h0, RESP_OKAY);
		axi_rd(8'h1C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
		axi_wr(OFS_PIN_LEVEL, 32'hFFFF, RESP_SLVERR);
		axi_wr(OFS_PORTB_DATA, 32'hFFFFFFFF, RESP_OKAY);
		axi_rd(OFS_PORTB_DATA, 32'hFFFFFFFF, 32'hFF, RESP_OKAY);
		$display("t_regs done");
	endtask : t_regs
	// plain port use of all pins
	task automatic t_port;
		axi_wr(OFS_PORTB_DIR, 32'hFF, RESP_OKAY);
		axi_wr(OFS_PORTC_DIR, 32'hFF, RESP_OKAY);
		axi_wr(OFS_PORTB_DATA, 32'hA5, RESP_OKAY);
		axi_wr(OFS_PORTC_DATA, 32'h3C, RESP_OKAY);
		wait_n(3);
		chk("pin_oe", 32'(pin_oe), 32'hFFFF);
		chk("pin_out", 32'(pin_out), 32'h3CA5);
		$display("t_port done");
	endtask : t_port
	// transmit and clock outputs take the pins over, port data ignored
	task automatic t_periph;
		logic [15:0] e;
		axi_wr(OFS_PORTB_DIR, 32'h0, RESP_OKAY);
		axi_wr(OFS_PORTC_DIR, 32'h0, RESP_OKAY);
		axi_wr(OFS_FUNC, 32'h00FF, RESP_OKAY);
		for (int p = 0; p < 2; p++)
		begin
			serial_tx <= p ? 4'h5 : 4'hA;
			serial_sck <= p ? 4'hA : 4'h5;
			wait_n(3);
			e = 16'h0000;
			for (int n = 0; n < CH_N; n++)
			begin
				e[TX_POS[n]] = serial_tx[n];
				e[CLK_POS[n]] = serial_sck[n];
			end
			chk("own_oe", 32'(pin_oe), 32'h0B6D);
			chk("own_out", 32'(pin_out & 16'h0B6D), 32'(e));
		end
		axi_wr(OFS_FUNC, 32'h0, RESP_OKAY);
		wait_n(3);
		chk("clk0_oe", 32'(pin_oe[2]), 32'h0);
		axi_rd(OFS_PIN_LEVEL, 32'h4, 32'h4, RESP_OKAY);
		$display("t_periph done");
	endtask : t_periph
	// input functions sampled from their pins
	task automatic t_inputs;
		logic [15:0] pat [2];
		pat = '{16'h2925, 16'h16DA};
		axi_wr(OFS_FUNC, 32'h7F00, RESP_OKAY);
		for (int i = 0; i < 2; i++)
		begin
			ext_lvl <= pat[i];
			req2 <= 1'(i);
			wait_n(3);
			chk("rx", 32'(serial_rx), i ? 32'hF : 32'h0);
			chk("ext_clk", 32'(ext_clk), i ? 32'h0 : 32'hF);
			chk("cts", 32'(cts), 32'(i));
			chk("trg", 32'(trg), 32'(1 - i));
			chk("req", 32'(req), 32'(i));
			chk("conv", 32'(conv), 32'(i));
		end
		axi_wr(OFS_FUNC, 32'h0, RESP_OKAY);
		ext_lvl <= 16'h3925;
		wait_n(3);
		chk("off", 32'({ext_clk, cts, trg, req}), 32'h0);
		chk("rx_off", 32'({serial_rx, conv}), 32'h1);
		axi_wr(OFS_FUNC, 32'h0F00, RESP_OKAY);
		axi_wr(OFS_PORTB_DIR, 32'hFF, RESP_OKAY);
		wait_n(3);
		chk("ext_clk_dir", 32'(ext_clk), 32'hC);
		axi_wr(OFS_PORTB_DIR, 32'h0, RESP_OKAY);
		$display("t_inputs done");
	endtask : t_inputs
	// stabilisation wait after reset and after a stop wake
	task automatic t_stab;
		int n;
		chk("early", 32'(osc_stable), 32'h0);
		n = 0;
		while (osc_stable !== 1'b1 && n < 5000)
		begin
			@(posedge aclk);
			n++;
		end
		axi_rd(OFS_STATUS, 32'h1, 32'h1, RESP_OKAY);
		stop_wake <= 1'b1;
		@(posedge aclk);
		stop_wake <= 1'b0;
		wait_n(3);
		chk("wake", 32'(osc_stable), 32'h0);
		axi_rd(OFS_STATUS, 32'h1, 32'h0, RESP_OKAY);
		$display("t_stab done");
	endtask : t_stab
	// main sequence; reset held five cycles as the system requires
	initial
	begin
		{aresetn, awvalid, wvalid, arvalid, req2, stop_wake} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		{ext_lvl, serial_tx, serial_sck} = 24'h0;
		bad_count = 0;
		cmp_count = 0;
		wait_n(5);
		aresetn <= 1'b1;
		t_regs();
		t_port();
		t_periph();
		t_inputs();
		t_stab();
		conclude();
	end
	// watchdog well beyond the stabilisation wait
	initial
	begin
		#100000;
		bad_count++;
		conclude();
	end
endmodule : tb_serial_port_pin_sharing
`default_nettype wire
